// *** src/kmm_top.sv ***
/* Keypad mode and menu controller: boot mode pick from the held key,
   settings menu, test print, diagnostics, APB status/control.
   Assumes keys arrive raw from pins; raster ticks are on pclk.
// Function
// - No key: controller mode, heat, motor, wait/ready
// - Mode latched at power-on until power cycle
// - Key 2 over 3 s: settings, density
// - Key 2 toggles density and tray size
// - Key 1 steps density 0 to 4, wraps
// - Density kept nonvolatile, drives laser intensity
// - Fourteen tray sizes, kept nonvolatile
// - Key 1 steps tray list, wraps
// - Key 2 held 2 s then released: test print
// - Test print shows wait/ready with count
// - Key 1 starts/stops printing; scanner always on
// - Engine draws 128-dot grid inside border
// - Key 1 at power-on: diagnostics, code 30
// - Memory check error refuses diagnostics
// - Codes 80, 81, 85 pulse 500 ms
// - Display codes 30, 02, 07, 08
// - Codes 84, 85, 86 solenoids, 90 motor
// - Codes 91 to 95 enable high voltage
*/
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module kmm_top import kmm_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int PAGE_DOTS = 2400,
  parameter int PAGE_LINES = 3300,
  parameter int BORDER_DOTS = 47,
  parameter int POS_W = 13
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Service keypad pins
  input wire logic key1_in,
  input wire logic key2_in,
  // Raster timing
  input wire logic dot_tick,
  input wire logic line_tick,
  input wire logic page_start,
  // Engine drives and display
  output kmm_act_type act,
  output kmm_disp_type disp,
  output logic [2:0] laser_level,
  output logic [3:0] tray_size,
  output logic test_dot
);
  localparam int MSW = $clog2(MS_CYC);
  localparam int GL = $clog2(GRID_PITCH_DOTS);

  kmm_mode_type mode_r;
  kmm_act_type act_r;
  kmm_disp_type disp_r;
  logic [MSW-1:0] ms_cnt_r;
  logic ms_tick;
  logic [1:0] key_raw, key_db, key_prev_r, press;
  logic [11:0] hold_ms_r;
  logic [1:0] ld_step_r, nv_raddr, nv_waddr_r;
  logic ld_done, nv_we_r, opt_r, ready, printing_r, running_r;
  logic [7:0] nv_wdata_r, nv_rdata, run_code_r, sel_code;
  logic [2:0] density_r, next_density, ctrl_r, laser_r;
  logic [3:0] tray_r, next_tray, tray_out_r, sel_r;
  logic page_pulse_r, sol_live, test_dot_r;
  logic [15:0] test_cnt_r, total_cnt_r;
  logic [9:0] sol_ms_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [POS_W-1:0] x_r, y_r, x_off, y_off;
  logic in_x, in_y;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Millisecond timebase and key conditioning
  // ----------------------------------------------------------------
  // Free-running millisecond divider from reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= '0;
    end else if (ce) begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
    end
  end
  assign ms_tick = (ms_cnt_r == MSW'(MS_CYC - 1));

  assign key_raw = {key2_in, key1_in};
  for (genvar g = 0; g < 2; g++) begin : g_key
    logic s1_r, s2_r, db_r;
    logic [4:0] cnt_r;
    // Two-flop sync, then accept after a stable debounce interval
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        db_r <= 1'b0;
        cnt_r <= '0;
      end else if (ce) begin
        s1_r <= key_raw[g];
        s2_r <= s1_r;
        if (s2_r == db_r) begin
          cnt_r <= '0;
        end else if (ms_tick) begin
          if (cnt_r == 5'(DEBOUNCE_MS - 1)) begin
            db_r <= s2_r;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
      end
    end
    assign key_db[g] = db_r;
  end

  // Press edge detect on debounced keys
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_prev_r <= 2'h0;
    end else if (ce) begin
      key_prev_r <= key_db;
    end
  end
  assign press = key_db & ~key_prev_r;

  // ----------------------------------------------------------------
  // Power-on mode selection
  // ----------------------------------------------------------------
  // Hold timer from power-on, then a one-way pick of the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_BOOT;
      hold_ms_r <= 12'h000;
    end else if (ce) begin
      if (ms_tick && hold_ms_r != 12'hfff) begin
        hold_ms_r <= hold_ms_r + 12'h001;
      end
      case (mode_r)
        MODE_BOOT: begin
          if (ld_done && hold_ms_r >= 12'(BOOT_SAMPLE_MS)) begin
            if (key_db[0]) begin
              mode_r <= ctrl_r[CTRL_MEM_ERR] ? MODE_NORMAL : MODE_DIAG;
            end else if (key_db[1]) begin
              mode_r <= MODE_HOLD;
            end else begin
              mode_r <= MODE_NORMAL;
            end
          end
        end
        MODE_HOLD: begin
          if (hold_ms_r > 12'(HOLD_USER_MS)) begin
            mode_r <= MODE_USER;
          end else if (!key_db[1]) begin
            mode_r <= (hold_ms_r >= 12'(HOLD_TEST_MS)) ?
                      MODE_TEST : MODE_NORMAL;
          end
        end
        default: mode_r <= mode_r;
      endcase
    end
  end

  mode_latch_a: assert property (
    mode_r != $past(mode_r) |->
      $past(mode_r) == MODE_BOOT || $past(mode_r) == MODE_HOLD)
    else $error("mode changed after power-on pick");
  user_entry_a: assert property (
    $rose(mode_r == MODE_USER) |->
      $past(hold_ms_r) > 12'(HOLD_USER_MS) && disp_r.msg != MSG_TRAY)
    else $error("settings mode entered before 3 s hold");
  test_entry_a: assert property (
    $rose(mode_r == MODE_TEST) |->
      $past(hold_ms_r) >= 12'(HOLD_TEST_MS) &&
      $past(hold_ms_r) <= 12'(HOLD_USER_MS) && !$past(key_db[1]))
    else $error("test mode entered outside 2 to 3 s hold");
  diag_refuse_a: assert property (
    $rose(mode_r == MODE_DIAG) |-> !$past(ctrl_r[CTRL_MEM_ERR]) &&
      $past(key_db[0]) && sel_r == 4'h0)
    else $error("diagnostics entered wrongly");

  // ----------------------------------------------------------------
  // Settings menu and nonvolatile store
  // ----------------------------------------------------------------
  assign ld_done = (ld_step_r == 2'h3);
  assign nv_raddr = (ld_step_r == 2'h0) ? NV_DENSITY : NV_TRAY;
  assign next_density = (density_r == 3'(DENSITY_MAX)) ?
                        3'h0 : density_r + 3'h1;
  assign next_tray = (tray_r == 4'(SIZE_COUNT - 1)) ?
                     4'h0 : tray_r + 4'h1;

  // Loader steps through the stored settings after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_step_r <= 2'h0;
    end else if (ce && !ld_done) begin
      ld_step_r <= ld_step_r + 2'h1;
    end
  end

  // Menu state, reload from store and write-back on each change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      density_r <= DENSITY_RST;
      tray_r <= TRAY_RST;
      opt_r <= 1'b0;
      nv_we_r <= 1'b0;
      nv_waddr_r <= NV_DENSITY;
      nv_wdata_r <= 8'h00;
    end else if (ce) begin
      nv_we_r <= 1'b0;
      if (ld_step_r == 2'h1) begin
        density_r <= (nv_rdata[2:0] > 3'(DENSITY_MAX)) ?
                     DENSITY_RST : nv_rdata[2:0];
      end else if (ld_step_r == 2'h2) begin
        tray_r <= (nv_rdata[3:0] >= 4'(SIZE_COUNT)) ?
                  TRAY_RST : nv_rdata[3:0];
      end else if (mode_r == MODE_USER) begin
        if (press[1]) begin
          opt_r <= ~opt_r;
        end else if (press[0] && !opt_r) begin
          density_r <= next_density;
          nv_we_r <= 1'b1;
          nv_waddr_r <= NV_DENSITY;
          nv_wdata_r <= {5'h00, next_density};
        end else if (press[0]) begin
          tray_r <= next_tray;
          nv_we_r <= 1'b1;
          nv_waddr_r <= NV_TRAY;
          nv_wdata_r <= {4'h0, next_tray};
        end
      end
    end
  end

  kmm_nvmem #(.W(8), .DEPTH(4)) u_nvmem (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .we(nv_we_r),
    .waddr(nv_waddr_r),
    .wdata(nv_wdata_r),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );

  density_wrap_a: assert property (
    ce && mode_r == MODE_USER && !opt_r && press == 2'h1 &&
    density_r == 3'(DENSITY_MAX) |=> density_r == 3'h0 && nv_we_r)
    else $error("density did not wrap to 0");
  tray_wrap_a: assert property (
    ce && mode_r == MODE_USER && opt_r && press == 2'h1 &&
    tray_r == 4'(SIZE_COUNT - 1) |=> tray_r == 4'h0 ##2 tray_size == 4'h0)
    else $error("tray size did not wrap to first entry");

  // ----------------------------------------------------------------
  // Test print mode
  // ----------------------------------------------------------------
  assign ready = ctrl_r[CTRL_AT_TEMP] && !ctrl_r[CTRL_FAULT];

  // Start/stop and page counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      printing_r <= 1'b0;
      test_cnt_r <= 16'h0000;
      total_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (mode_r == MODE_TEST && press[0] && ready) begin
        printing_r <= ~printing_r;
      end else if (!ready) begin
        printing_r <= 1'b0;
      end
      if (page_pulse_r) begin
        total_cnt_r <= total_cnt_r + 16'h0001;
        if (printing_r) begin
          test_cnt_r <= test_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Grid generator: one-dot lines every pitch inside the border
  assign x_off = x_r - POS_W'(BORDER_DOTS);
  assign y_off = y_r - POS_W'(BORDER_DOTS);
  assign in_x = x_r >= POS_W'(BORDER_DOTS) &&
                x_r < POS_W'(PAGE_DOTS - BORDER_DOTS);
  assign in_y = y_r >= POS_W'(BORDER_DOTS) &&
                y_r < POS_W'(PAGE_LINES - BORDER_DOTS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_r <= '0;
      y_r <= '0;
      test_dot_r <= 1'b0;
    end else if (ce) begin
      if (page_start) begin
        x_r <= '0;
        y_r <= '0;
      end else if (line_tick) begin
        x_r <= '0;
        y_r <= y_r + 1'b1;
      end else if (dot_tick) begin
        x_r <= x_r + 1'b1;
      end
      test_dot_r <= printing_r && dot_tick && in_x && in_y &&
                    (x_off[GL-1:0] == '0 || y_off[GL-1:0] == '0);
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics
  // ----------------------------------------------------------------
  assign sel_code = DIAG_TABLE[sel_r];
  assign sol_live = sol_ms_r < 10'(SOL_PULSE_MS);

  // Code selection, run and exit through code 00
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 4'h0;
      running_r <= 1'b0;
      run_code_r <= DG_EXIT;
      sol_ms_r <= 10'h000;
    end else if (ce && mode_r == MODE_DIAG) begin
      if (running_r && ms_tick && sol_live) begin
        sol_ms_r <= sol_ms_r + 10'h001;
      end
      if (press[1]) begin
        sel_r <= (sel_r == 4'(DIAG_COUNT - 1)) ? 4'h0 : sel_r + 4'h1;
      end else if (press[0]) begin
        if (sel_code == DG_EXIT) begin
          running_r <= 1'b0;
          run_code_r <= DG_EXIT;
        end else if (!running_r) begin
          running_r <= 1'b1;
          run_code_r <= sel_code;
          sol_ms_r <= 10'h000;
        end
      end
    end
  end

  // Engine drives by mode and running code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= '0;
    end else if (ce) begin
      act_r.fuser_heat <= mode_r == MODE_NORMAL || mode_r == MODE_TEST;
      act_r.main_motor <= mode_r == MODE_NORMAL ||
                          mode_r == MODE_TEST ||
                          (running_r && run_code_r == DG_MOTOR);
      act_r.scanner_motor <= mode_r == MODE_TEST;
      act_r.solenoid[SOL_TRAY0] <= running_r && sol_live &&
                                   run_code_r == DG_SOL_TRAY0;
      act_r.solenoid[SOL_TRAY1] <= running_r && sol_live &&
                                   run_code_r == DG_SOL_TRAY1;
      act_r.solenoid[SOL_LOWER] <= running_r && sol_live &&
                                   run_code_r == DG_TURN_LOWER;
      act_r.solenoid[SOL_UPPER] <= running_r &&
                                   run_code_r == DG_TURN_UPPER;
      act_r.solenoid[SOL_TRAY2] <= running_r &&
                                   run_code_r == DG_SOL_TRAY2;
      for (int i = 0; i < 5; i++) begin
        act_r.hv[i] <= running_r &&
                       run_code_r == DG_HV_FIRST + 8'(i);
      end
    end
  end

  sol_pulse_a: assert property (
    act_r.solenoid[SOL_TRAY0] || act_r.solenoid[SOL_TRAY1] ||
    act_r.solenoid[SOL_LOWER] |->
      sol_ms_r <= 10'(SOL_PULSE_MS) && $past(running_r))
    else $error("solenoid held past its pulse");
  hv_single_a: assert property (
    ce && running_r && run_code_r == 8'h93 |=> act_r.hv == 5'h04)
    else $error("wrong high voltage output enabled");
  normal_drive_a: assert property (
    ce && mode_r == MODE_NORMAL |=>
      act_r.fuser_heat && act_r.main_motor && act_r.hv == 5'h00)
    else $error("normal mode without fuser and motor");

  // ----------------------------------------------------------------
  // Display and settings outputs
  // ----------------------------------------------------------------
  // Message and value per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_r <= '0;
      laser_r <= DENSITY_RST;
      tray_out_r <= TRAY_RST;
    end else if (ce) begin
      laser_r <= density_r;
      tray_out_r <= tray_r;
      disp_r.val <= 16'h0000;
      case (mode_r)
        MODE_NORMAL: disp_r.msg <= ready ? MSG_READY : MSG_WAIT;
        MODE_USER: begin
          disp_r.msg <= opt_r ? MSG_TRAY : MSG_DENSITY;
          disp_r.val <= opt_r ? {12'h000, tray_r} : {13'h0, density_r};
        end
        MODE_TEST: begin
          disp_r.msg <= ready ? MSG_TEST_READY : MSG_TEST_WAIT;
          disp_r.val <= test_cnt_r;
        end
        MODE_DIAG: begin
          disp_r.msg <= running_r ? MSG_DIAG_RUN : MSG_DIAG_SEL;
          disp_r.val <= (running_r && run_code_r == DG_PRINT_COUNT) ?
                        total_cnt_r : {run_code_r, sel_code};
        end
        default: disp_r.msg <= MSG_BLANK;
      endcase
    end
  end

  test_wait_a: assert property (
    ce && mode_r == MODE_TEST && !ready |=>
      disp.msg == MSG_TEST_WAIT && !printing_r)
    else $error("test print not waiting for warm-up");

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Decode in setup, answer in a one-cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RST;
      page_pulse_r <= 1'b0;
    end else if (ce) begin
      page_pulse_r <= 1'b0;
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !(paddr inside {ADDR_STATUS, ADDR_CTRL,
                                     ADDR_SETTINGS, ADDR_COUNT});
        case (paddr)
          ADDR_STATUS: prdata_r <= {20'h00000, disp_r.msg, mode_r, opt_r,
                                    running_r, printing_r, ready, ld_done};
          ADDR_CTRL: prdata_r <= {29'h0, ctrl_r};
          ADDR_SETTINGS: prdata_r <= {20'h00000, tray_r, 5'h00, density_r};
          ADDR_COUNT: prdata_r <= {test_cnt_r, total_cnt_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
      if (psel && penable && pready_r && pwrite && paddr == ADDR_CTRL) begin
        ctrl_r <= pwdata[2:0];
        page_pulse_r <= pwdata[CTRL_PAGE_DONE];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign act = act_r;
  assign disp = disp_r;
  assign laser_level = laser_r;
  assign tray_size = tray_out_r;
  assign test_dot = test_dot_r;
endmodule : kmm_top

// *** src/kmm_pkg.sv ***
/* Shared definitions of the keypad mode and menu controller: timebase,
   hold times, menu limits, diagnostic codes, register map and carriers.
   Assumes pclk runs at 40 MHz. */
package kmm_pkg;
  // ----------------------------------------------------------------
  // Timebase and hold times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = MS_US * CLK_MHZ;
  localparam int DEBOUNCE_MS = 20;
  localparam int BOOT_SAMPLE_MS = DEBOUNCE_MS + 2;
  localparam int HOLD_TEST_MS = 2000;
  localparam int HOLD_USER_MS = 3000;
  localparam int SOL_PULSE_MS = 500;

  // ----------------------------------------------------------------
  // Menu limits and test page
  // ----------------------------------------------------------------
  localparam int DENSITY_MAX = 4;
  localparam logic [2:0] DENSITY_RST = 3'h0;
  localparam int SIZE_COUNT = 14;
  localparam logic [3:0] TRAY_RST = 4'h0;
  localparam int GRID_PITCH_DOTS = 128;

  // ----------------------------------------------------------------
  // Diagnostic codes in numeric order, then the table in selection order
  // ----------------------------------------------------------------
  localparam logic [7:0] DG_EXIT = 8'h00;
  localparam logic [7:0] DG_SENSOR = 8'h02;
  localparam logic [7:0] DG_FUSER_SET = 8'h07;
  localparam logic [7:0] DG_FUSER_ACT = 8'h08;
  localparam logic [7:0] DG_PRINT_COUNT = 8'h30;
  localparam logic [7:0] DG_SOL_TRAY0 = 8'h80;
  localparam logic [7:0] DG_SOL_TRAY1 = 8'h81;
  localparam logic [7:0] DG_TURN_UPPER = 8'h84;
  localparam logic [7:0] DG_TURN_LOWER = 8'h85;
  localparam logic [7:0] DG_SOL_TRAY2 = 8'h86;
  localparam logic [7:0] DG_MOTOR = 8'h90;
  localparam logic [7:0] DG_HV_FIRST = 8'h91;
  localparam int DIAG_COUNT = 16;
  localparam logic [7:0] DIAG_TABLE [DIAG_COUNT] = '{
    DG_PRINT_COUNT, DG_SENSOR, DG_FUSER_SET, DG_FUSER_ACT,
    DG_SOL_TRAY0, DG_SOL_TRAY1, DG_SOL_TRAY2, DG_TURN_UPPER,
    DG_TURN_LOWER, DG_MOTOR, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95,
    DG_EXIT};
  localparam int SOL_TRAY0 = 0;
  localparam int SOL_TRAY1 = 1;
  localparam int SOL_TRAY2 = 2;
  localparam int SOL_UPPER = 3;
  localparam int SOL_LOWER = 4;

  // ----------------------------------------------------------------
  // APB register map and settings store
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_SETTINGS = 12'h008;
  localparam logic [11:0] ADDR_COUNT = 12'h00c;
  localparam int CTRL_AT_TEMP = 0;
  localparam int CTRL_FAULT = 1;
  localparam int CTRL_MEM_ERR = 2;
  localparam int CTRL_PAGE_DONE = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] NV_DENSITY = 2'h0;
  localparam logic [1:0] NV_TRAY = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_BOOT, MODE_HOLD, MODE_NORMAL, MODE_USER, MODE_TEST, MODE_DIAG
  } kmm_mode_type;
  typedef enum logic [3:0] {
    MSG_BLANK, MSG_WAIT, MSG_READY, MSG_DENSITY, MSG_TRAY,
    MSG_TEST_WAIT, MSG_TEST_READY, MSG_DIAG_SEL, MSG_DIAG_RUN
  } kmm_msg_type;
  typedef struct packed {
    logic fuser_heat;
    logic main_motor;
    logic scanner_motor;
    logic [4:0] solenoid;
    logic [4:0] hv;
  } kmm_act_type;
  typedef struct packed {
    kmm_msg_type msg;
    logic [15:0] val;
  } kmm_disp_type;
endpackage : kmm_pkg

// *** src/kmm_nvmem.sv ***
/* Small settings store standing in for the nonvolatile memory.
   Contents are not touched by presetn; read data leave a register. */
`timescale 1ns/1ps
module kmm_nvmem #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  // Blank store at first power-up only
  logic [W-1:0] mem [DEPTH] = '{default: '0};

  // Write port, kept across engine resets
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule : kmm_nvmem

// *** verif/kmm_keypad.sv ***
/* Service keypad model: two keys, held level high.
   Assumes its tasks are called from the pclk domain. */
`timescale 1ns/1ps
module kmm_keypad #(
  parameter int MS = 4
) (
  // Clock
  input wire logic clk,
  // Key pins
  output logic key1,
  output logic key2
);
  initial begin
    key1 = 1'b0;
    key2 = 1'b0;
  end
  // Sets both key levels just after an edge
  task automatic hold(input logic k1, input logic k2);
    @(posedge clk);
    key1 <= k1;
    key2 <= k2;
  endtask : hold
  // Keeps the levels for n milliseconds
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask : wait_ms
  // One press held well past debounce, then let go
  task automatic press(input logic k1, input logic k2);
    hold(k1, k2);
    wait_ms(30);
    hold(1'b0, 1'b0);
    wait_ms(30);
  endtask : press
endmodule : kmm_keypad

// *** verif/kmm_top_bench.sv ***
/* Bench of the keypad mode and menu controller.
   Assumes MS_CYC scaled down to 4 cycles a millisecond. */
`timescale 1ns/1ps
module kmm_top_bench import kmm_pkg::*;;
  localparam int MS = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic key1, key2;
  logic ce, dot_tick, line_tick, page_start, test_dot;
  kmm_act_type act;
  kmm_disp_type disp;
  logic [2:0] laser_level;
  logic [3:0] tray_size;
  int fail_count = 0;
  int check_count = 0;
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
  kmm_top #(.MS_CYC(MS)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key1_in(key1), .key2_in(key2), .dot_tick(dot_tick),
    .line_tick(line_tick), .page_start(page_start), .act(act), .disp(disp),
    .laser_level(laser_level), .tray_size(tray_size), .test_dot(test_dot));
  kmm_keypad #(.MS(MS)) u_keys (.clk(pclk), .key1(key1), .key2(key2));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Power cycle with keys held and memory check result given
  task automatic power_on(input logic k1, input logic k2, input logic me);
    presetn <= 1'b0;
    u_keys.hold(k1, k2);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ADDR_CTRL, {29'h0, me, 2'h0});
    u_keys.wait_ms(40);
  endtask : power_on
  // Status mode field and shown message
  task automatic chk_mode(input logic [2:0] m, input kmm_msg_type g);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("mode", m, rd[7:5])
    `CHK("msg", g, disp.msg)
  endtask : chk_mode
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    repeat (80000) @(posedge pclk);
    fail_count++;
    final_report();
  end
  // Tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ce = 1'b1;
    dot_tick = 1'b0;
    line_tick = 1'b0;
    page_start = 1'b0;
    power_on(1'b0, 1'b0, 1'b0);
    chk_mode(3'h2, MSG_WAIT);
    `CHK("heat", 2'h3, {act.fuser_heat, act.main_motor})
    apb(1'b1, ADDR_CTRL, 32'h1);
    u_keys.press(1'b1, 1'b0);
    chk_mode(3'h2, MSG_READY);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("test normal done");
    power_on(1'b1, 1'b0, 1'b1);
    chk_mode(3'h2, MSG_WAIT);
    power_on(1'b1, 1'b0, 1'b0);
    u_keys.hold(1'b0, 1'b0);
    u_keys.wait_ms(30);
    chk_mode(3'h5, MSG_DIAG_SEL);
    `CHK("code", 16'h0030, disp.val)
    for (int i = 0; i < 4; i++) u_keys.press(1'b0, 1'b1);
    `CHK("code", 16'h0080, disp.val)
    u_keys.press(1'b1, 1'b0);
    `CHK("sol", 1'b1, act.solenoid[SOL_TRAY0])
    u_keys.wait_ms(480);
    `CHK("sol", 1'b0, act.solenoid[SOL_TRAY0])
    for (int i = 0; i < 11; i++) u_keys.press(1'b0, 1'b1);
    u_keys.press(1'b1, 1'b0);
    chk_mode(3'h5, MSG_DIAG_SEL);
    for (int i = 0; i < 13; i++) u_keys.press(1'b0, 1'b1);
    u_keys.press(1'b1, 1'b0);
    `CHK("hv", 5'h04, act.hv)
    `CHK("code", 16'h9393, disp.val)
    $display("test diag done");
    power_on(1'b0, 1'b1, 1'b0);
    u_keys.wait_ms(3100);
    u_keys.hold(1'b0, 1'b0);
    u_keys.wait_ms(30);
    chk_mode(3'h3, MSG_DENSITY);
    for (int i = 1; i <= 6; i++) begin
      u_keys.press(1'b1, 1'b0);
      `CHK("density", 3'(i % 5), laser_level)
    end
    u_keys.press(1'b0, 1'b1);
    chk_mode(3'h3, MSG_TRAY);
    for (int i = 1; i <= 15; i++) begin
      u_keys.press(1'b1, 1'b0);
      `CHK("tray", 4'(i % 14), tray_size)
    end
    $display("test user done");
    power_on(1'b0, 1'b1, 1'b0);
    u_keys.wait_ms(2460);
    u_keys.hold(1'b0, 1'b0);
    u_keys.wait_ms(30);
    chk_mode(3'h4, MSG_TEST_WAIT);
    `CHK("count", 16'h0000, disp.val)
    apb(1'b0, ADDR_SETTINGS, 32'h0);
    `CHK("settings", 32'h101, rd)
    apb(1'b1, ADDR_CTRL, 32'h1);
    chk_mode(3'h4, MSG_TEST_READY);
    u_keys.press(1'b1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("printing", 2'h3, {rd[2], act.scanner_motor})
    apb(1'b1, ADDR_CTRL, 32'h9);
    apb(1'b0, ADDR_COUNT, 32'h0);
    `CHK("count", 32'h0001_0001, rd)
    `CHK("count", 16'h0001, disp.val)
    page_start <= 1'b1;
    @(posedge pclk) page_start <= 1'b0;
    line_tick <= 1'b1;
    repeat (48) @(posedge pclk);
    line_tick <= 1'b0;
    dot_tick <= 1'b1;
    repeat (48) @(posedge pclk);
    @(negedge pclk) `CHK("dot", 1'b1, test_dot)
    @(posedge pclk) dot_tick <= 1'b0;
    @(negedge pclk) `CHK("dot", 1'b0, test_dot)
    @(posedge pclk) ce <= 1'b0;
    u_keys.press(1'b1, 1'b0);
    ce <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("frozen", 1'b1, rd[2])
    u_keys.press(1'b1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("printing", 2'h1, {rd[2], act.scanner_motor})
    $display("test print done");
    final_report();
  end
endmodule : kmm_top_bench
